// File: src/lbx_defines.vh
// Shared constants for the local bus transceiver and hold controller
`ifndef LBX_DEFINES_VH
`define LBX_DEFINES_VH

// Bus cycle T-states
`define LBX_ST_TI       3'h0
`define LBX_ST_T1       3'h1
`define LBX_ST_T2       3'h2
`define LBX_ST_T3       3'h3
`define LBX_ST_TW       3'h4
`define LBX_ST_T4       3'h5
`define LBX_ST_HOLD     3'h6
`define LBX_ST_W        3

// Cycle kinds requested by the core
`define LBX_KIND_MEM_RD 2'h0
`define LBX_KIND_MEM_WR 2'h1
`define LBX_KIND_IO_RD  2'h2
`define LBX_KIND_IO_WR  2'h3
`define LBX_KIND_W      2

// Phases within one T-state: clock high half then low half
`define LBX_PH_HI       1'b0
`define LBX_PH_LO       1'b1

// Direction levels on the transceiver
`define LBX_DIR_TX      1'b1
`define LBX_DIR_RX      1'b0

`endif

// File: src/lbx_sync2.v
// Two-stage synchroniser for a single level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module lbx_sync2 (
	input  wire sys_clk_i,
	input  wire nrst_i,
	input  wire async_i,
	output wire sync_o
);
	reg meta_q;
	reg sync_q;

	// First stage feeds only the second
	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule
`default_nettype wire

// File: src/lbx_bus_ctrl.v
// Local bus cycle sequencer: transceiver steering and hold handshake
// Summary of operation
// - Direction is high when transmitting, low when receiving.
// - Direction follows memory/IO select timing; equals status bit one.
// - Direction floats while the bus is granted away.
// - Data enable asserts low in memory, IO and interrupt-ack cycles.
// - Read or irq-ack: enable from middle of T2 to middle of T4.
// - Write: enable from start of T2 to middle of T4.
// - Data enable floats while the bus is granted away.
// - Acknowledge rises at the end of T4 or idle, never inside a cycle.
// - Bus and control lines float together with the acknowledge.
// - Acknowledge drops once hold request is seen low.
// - Lines are driven again only when the next cycle starts.
`timescale 1ns/1ps
`default_nettype none
`include "lbx_defines.vh"
module lbx_bus_ctrl (
	input  wire                     sys_clk_i,
	input  wire                     nrst_i,
	input  wire                     cyc_req_i,
	input  wire [`LBX_KIND_W-1:0]   cyc_kind_i,
	input  wire                     cyc_irq_ack_i,
	input  wire                     ready_i,
	input  wire                     hold_req_i,
	output reg                      cyc_busy_o,
	output reg                      cyc_done_o,
	output reg                      mem_io_sel_o,
	output reg                      status_bit_one_o,
	output reg                      xcvr_direction_o,
	output reg                      xcvr_direction_oe_o,
	output reg                      xcvr_output_enable_n_o,
	output reg                      xcvr_output_enable_n_oe_o,
	output reg                      irq_ack_strobe_n_o,
	output reg                      ctrl_oe_o,
	output reg                      bus_grant_ack_o,
	output reg  [2:0]               tstate_o
);
	// The core runs two phases per T-state, so one T-state spans two
	// sys_clk edges; this gives the half-cycle placement the strobes need.
	reg  [2:0]             st_q;
	reg  [2:0]             st_d;
	reg                    ph_q;
	reg  [`LBX_KIND_W-1:0] kind_q;
	reg                    iack_q;
	reg                    grant_q;
	reg                    grant_d;
	wire                   hold_s;
	wire                   ready_s;

	// External pins cross into the clock domain before use
	lbx_sync2 u_hold_sync (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.async_i   (hold_req_i),
		.sync_o    (hold_s)
	);

	lbx_sync2 u_rdy_sync (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.async_i   (ready_i),
		.sync_o    (ready_s)
	);

	function is_write;
		input [`LBX_KIND_W-1:0] k;
		begin
			is_write = (k == `LBX_KIND_MEM_WR) || (k == `LBX_KIND_IO_WR);
		end
	endfunction

	function is_io;
		input [`LBX_KIND_W-1:0] k;
		begin
			is_io = (k == `LBX_KIND_IO_RD) || (k == `LBX_KIND_IO_WR);
		end
	endfunction

	// Next T-state, evaluated at the end of a T-state (low phase)
	always @* begin
		st_d    = st_q;
		grant_d = grant_q;
		case (st_q)
		`LBX_ST_TI: begin
			if (hold_s) begin
				st_d    = `LBX_ST_HOLD;
				grant_d = 1'b1;
			end else if (cyc_req_i) begin
				st_d = `LBX_ST_T1;
			end
		end
		`LBX_ST_T1: st_d = `LBX_ST_T2;
		`LBX_ST_T2: st_d = `LBX_ST_T3;
		`LBX_ST_T3: st_d = ready_s ? `LBX_ST_T4 : `LBX_ST_TW;
		`LBX_ST_TW: st_d = ready_s ? `LBX_ST_T4 : `LBX_ST_TW;
		`LBX_ST_T4: begin
			if (hold_s) begin
				st_d    = `LBX_ST_HOLD;
				grant_d = 1'b1;
			end else if (cyc_req_i) begin
				st_d = `LBX_ST_T1;
			end else begin
				st_d = `LBX_ST_TI;
			end
		end
		`LBX_ST_HOLD: begin
			if (!hold_s) begin
				st_d    = `LBX_ST_TI;
				grant_d = 1'b0;
			end
		end
		default: begin
			st_d    = `LBX_ST_TI;
			grant_d = 1'b0;
		end
		endcase
	end

	// Sequencer state and latched cycle attributes
	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q    <= `LBX_ST_TI;
			ph_q    <= `LBX_PH_HI;
			kind_q  <= `LBX_KIND_MEM_RD;
			iack_q  <= 1'b0;
			grant_q <= 1'b0;
		end else begin
			ph_q <= ~ph_q;
			if (ph_q == `LBX_PH_LO) begin
				st_q <= st_d;
				// Hold is granted at the T-state boundary, which on
				// the pins reads as the end of T4 or TI, as tstate_o leaves it.
				grant_q <= grant_d;
				if (st_d == `LBX_ST_T1) begin
					kind_q <= cyc_kind_i;
					iack_q <= cyc_irq_ack_i;
				end
			end
		end
	end

	// Pin outputs, all registered
	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cyc_busy_o                <= 1'b0;
			cyc_done_o                <= 1'b0;
			mem_io_sel_o              <= 1'b0;
			status_bit_one_o          <= `LBX_DIR_RX;
			xcvr_direction_o          <= `LBX_DIR_RX;
			xcvr_direction_oe_o       <= 1'b0;
			xcvr_output_enable_n_o    <= 1'b1;
			xcvr_output_enable_n_oe_o <= 1'b0;
			irq_ack_strobe_n_o        <= 1'b1;
			ctrl_oe_o                 <= 1'b0;
			bus_grant_ack_o           <= 1'b0;
			tstate_o                  <= `LBX_ST_TI;
		end else begin
			tstate_o        <= st_q;
			bus_grant_ack_o <= grant_q;
			cyc_busy_o      <= (st_q != `LBX_ST_TI) &&
				(st_q != `LBX_ST_HOLD);
			cyc_done_o      <= (st_q == `LBX_ST_T4) &&
				(ph_q == `LBX_PH_LO);
			// Direction and memory/IO change together at T1 start
			if (st_q == `LBX_ST_T1) begin
				mem_io_sel_o     <= is_io(kind_q) && !iack_q;
				xcvr_direction_o <= is_write(kind_q) && !iack_q;
				status_bit_one_o <= is_write(kind_q) && !iack_q;
			end
			// Float with the grant; drive again only at the next T1
			if (grant_q) begin
				xcvr_direction_oe_o       <= 1'b0;
				xcvr_output_enable_n_oe_o <= 1'b0;
				ctrl_oe_o                 <= 1'b0;
			end else if (st_q == `LBX_ST_T1) begin
				xcvr_direction_oe_o       <= 1'b1;
				xcvr_output_enable_n_oe_o <= 1'b1;
				ctrl_oe_o                 <= 1'b1;
			end
			// Data enable window
			if ((st_q == `LBX_ST_T2) && (ph_q == `LBX_PH_HI)) begin
				xcvr_output_enable_n_o <= !is_write(kind_q) || iack_q;
			end else if ((st_q == `LBX_ST_T2) && (ph_q == `LBX_PH_LO)) begin
				xcvr_output_enable_n_o <= 1'b0;
			end else if ((st_q == `LBX_ST_T4) && (ph_q == `LBX_PH_LO)) begin
				xcvr_output_enable_n_o <= 1'b1;
			end
			// Interrupt-acknowledge strobe over T2, T3 and waits
			// Launched with tstate_o, so it covers exactly those pin states
			irq_ack_strobe_n_o <= !(iack_q && ((st_q == `LBX_ST_T2) ||
				(st_q == `LBX_ST_T3) || (st_q == `LBX_ST_TW)));
		end
	end
endmodule
`default_nettype wire

// File: testbench/lbx_master_model.sv
// Other bus master: hold requester that also paces ready
`timescale 1ns/1ps
`default_nettype none
module lbx_master_model (
	input  wire logic sys_clk_i,
	input  wire logic nrst_i,
	input  wire logic want_i,
	input  wire logic slow_i,
	output var  logic hold_req_o,
	output var  logic ready_o
);
	logic [3:0] slow_cnt_q;

	// Registered, so the request is already in the device clock domain.
	// Slow: ready low for 15 clocks, then one high clock in every 7;
	// the odd period puts every second pulse on the two-clock wait sampling.
	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hold_req_o <= 1'b0;
			ready_o <= 1'b1;
			slow_cnt_q <= 4'h0;
		end else begin
			hold_req_o <= want_i;
			if (!slow_i) begin
				slow_cnt_q <= 4'h0;
				ready_o <= 1'b1;
			end else begin
				slow_cnt_q <= (slow_cnt_q == 4'hf) ? 4'h9 :
					slow_cnt_q + 4'h1;
				ready_o <= (slow_cnt_q == 4'hf);
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/lbx_bus_ctrl_asserts.sv
// Concurrent checks on the bus cycle sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "lbx_defines.vh"
module lbx_bus_ctrl_asserts (
	input wire logic       sys_clk_i,
	input wire logic       nrst_i,
	input wire logic       hold_req_i,
	input wire logic       cyc_busy_o,
	input wire logic       status_bit_one_o,
	input wire logic       xcvr_direction_o,
	input wire logic       xcvr_direction_oe_o,
	input wire logic       xcvr_output_enable_n_o,
	input wire logic       xcvr_output_enable_n_oe_o,
	input wire logic       irq_ack_strobe_n_o,
	input wire logic       ctrl_oe_o,
	input wire logic       bus_grant_ack_o,
	input wire logic [2:0] tstate_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	AST_DIR_STATUS: assert property (xcvr_direction_oe_o |->
		status_bit_one_o == xcvr_direction_o) else $error("dir status");
	AST_GRANT_FLOAT: assert property (bus_grant_ack_o |->
		!(xcvr_direction_oe_o || xcvr_output_enable_n_oe_o || ctrl_oe_o))
		else $error("driven in grant");
	AST_ACK_IDLE: assert property (bus_grant_ack_o |-> !cyc_busy_o)
		else $error("ack in cycle");
	AST_ACK_EDGE: assert property ($rose(bus_grant_ack_o) |->
		!($past(tstate_o) inside {`LBX_ST_T1, `LBX_ST_T2, `LBX_ST_T3,
		`LBX_ST_TW}))
		else $error("ack mid cycle");
	AST_ACK_DROP: assert property ($fell(hold_req_i) |->
		##[1:16] !bus_grant_ack_o) else $error("ack stuck");
	AST_NO_REDRIVE: assert property ($fell(bus_grant_ack_o) |->
		!ctrl_oe_o [*2]) else $error("early drive");
	AST_EN_WINDOW: assert property (!xcvr_output_enable_n_o |->
		tstate_o inside {[`LBX_ST_T2:`LBX_ST_T4]}) else $error("enable");
	AST_IRQ_RX: assert property (!irq_ack_strobe_n_o |->
		!xcvr_direction_o) else $error("irq dir");
	AST_TWO_CLK: assert property ($changed(tstate_o) &&
		tstate_o inside {[`LBX_ST_T1:`LBX_ST_T3]} |=> $stable(tstate_o))
		else $error("state length");
endmodule
bind lbx_bus_ctrl lbx_bus_ctrl_asserts u_chk (.*);
`default_nettype wire

// File: testbench/lbx_bus_ctrl_test.sv
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module lbx_bus_ctrl_test;
	logic sys_clk_i, nrst_i, cyc_req_i, cyc_irq_ack_i, want, slow;
	logic [1:0] cyc_kind_i;
	wire logic hold_req_i, ready_i, cyc_busy_o, cyc_done_o, mem_io_sel_o;
	wire logic status_bit_one_o, xcvr_direction_o, xcvr_direction_oe_o;
	wire logic xcvr_output_enable_n_o, xcvr_output_enable_n_oe_o;
	wire logic irq_ack_strobe_n_o, ctrl_oe_o, bus_grant_ack_o;
	wire logic [2:0] tstate_o;
	int num_errors = 0;
	int num_checks = 0;
	lbx_bus_ctrl uut (.*);
	lbx_master_model u_mst (.sys_clk_i, .nrst_i, .want_i(want),
		.slow_i(slow), .hold_req_o(hold_req_i), .ready_o(ready_i));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic run_cycle(input logic [1:0] k, input logic ia);
		int n, en, st, tx;
		n = 0; en = 0; st = 0; tx = 0;
		tick(1);
		cyc_req_i <= 1'b1; cyc_kind_i <= k; cyc_irq_ack_i <= ia;
		while (cyc_busy_o !== 1'b1 && n < 200) begin tick(1); n++; end
		cyc_req_i <= 1'b0;
		while (cyc_done_o !== 1'b1 && n < 200) begin
			tick(1); n++;
			en += (xcvr_output_enable_n_o === 1'b0);
			st += (irq_ack_strobe_n_o === 1'b0);
			tx += (xcvr_direction_o === 1'b1);
		end
		chk(n < 200, 1);
		chk(ctrl_oe_o, 1);
		if (slow) chk(en > 4, 1);
		else chk(en, (k[0] && !ia) ? 5 : 4);
		chk(st, ia ? 4 : 0);
		chk(tx != 0, k[0] && !ia);
		if (!ia) chk(mem_io_sel_o, k[1]);
	endtask
	task automatic hold_test(input int d);
		int n;
		n = 0;
		tick(1);
		cyc_req_i <= 1'b1; cyc_kind_i <= 2'h1; cyc_irq_ack_i <= 1'b0;
		tick(d);
		want <= 1'b1;
		while (bus_grant_ack_o !== 1'b1 && n < 100) begin tick(1); n++; end
		cyc_req_i <= 1'b0;
		chk(n < 100, 1);
		chk({cyc_busy_o, xcvr_direction_oe_o, xcvr_output_enable_n_oe_o,
			ctrl_oe_o}, 0);
		tick(12);
		chk(bus_grant_ack_o, 1);
		want <= 1'b0;
		n = 0;
		while (bus_grant_ack_o !== 1'b0 && n < 100) begin tick(1); n++; end
		chk(n < 100, 1);
		tick(6);
		chk(ctrl_oe_o, 0);
		run_cycle(2'h1, 1'b0);
	endtask
	initial begin
		sys_clk_i = 0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#40000;
		num_errors++;
		end_sim();
	end
	initial begin
		nrst_i = 0; cyc_req_i = 0; cyc_irq_ack_i = 0; want = 0; slow = 0;
		cyc_kind_i = 2'h0;
		tick(16);
		nrst_i <= 1'b1;
		for (int k = 0; k < 4; k++) run_cycle(k[1:0], 1'b0);
		run_cycle(2'h0, 1'b1);
		slow <= 1'b1;
		run_cycle(2'h2, 1'b0);
		slow <= 1'b0;
		hold_test(0);
		hold_test(6);
		end_sim();
	end
endmodule
`default_nettype wire
